// ---- tmr16_consts.vh ----
// constants for the 16-bit byte-access timer: register offsets, fields, reset values, counter landmarks, tick sources
// assumes a 32-bit APB slave, one byte-wide register per aligned word
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH

// register byte addresses
`define TMR16_OFF_CTRL_A      12'h000
`define TMR16_OFF_CTRL_B      12'h004
`define TMR16_OFF_COUNT_LOW   12'h008
`define TMR16_OFF_COUNT_HIGH  12'h00C
`define TMR16_OFF_CMP_A_LOW   12'h010
`define TMR16_OFF_CMP_A_HIGH  12'h014
`define TMR16_OFF_CMP_B_LOW   12'h018
`define TMR16_OFF_CMP_B_HIGH  12'h01C
`define TMR16_OFF_CAPT_LOW    12'h020
`define TMR16_OFF_CAPT_HIGH   12'h024
`define TMR16_OFF_FLAGS       12'h028
`define TMR16_OFF_POWER       12'h02C

// field positions
`define TMR16_A_WAVE_LO       1:0
`define TMR16_B_TICK_SEL      2:0
`define TMR16_B_WAVE_HI       4:3
`define TMR16_FLAG_OVF_BIT    0
`define TMR16_POWER_OFF_BIT   0

// reset values
`define TMR16_RST_BYTE        8'h00
`define TMR16_RST_WORD        16'h0000
`define TMR16_RST_MODE        4'h0
`define TMR16_RST_SEL         3'h0

// counter landmarks
`define TMR16_BOTTOM          16'h0000
`define TMR16_MAX             16'hFFFF
`define TMR16_TOP_8BIT        16'h00FF
`define TMR16_TOP_9BIT        16'h01FF
`define TMR16_TOP_10BIT       16'h03FF

// tick source selections
`define TMR16_SEL_NONE        3'h0
`define TMR16_SEL_SYSCLK      3'h1
`define TMR16_SEL_EXT_FALL    3'h6
`define TMR16_SEL_EXT_RISE    3'h7

`endif

// ---- tmr16_tick_sel.v ----
// tick selection: picks system clock, a prescaler tap or an external pin edge
// assumes prescale strobes and the pin are synchronous to pclk
`include "tmr16_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr16_tick_sel (
  input  wire       pclk,               // system clock
  input  wire       presetn,            // async reset, active low
  input  wire       run_enable,         // low while powered off
  input  wire [2:0] tick_source_select, // source code
  input  wire [3:0] prescale_tick,      // prescaler taps, one-cycle strobes
  input  wire       ext_pin,            // external count pin
  output reg        timer_tick          // one-cycle count strobe
);
  reg ext_prev;  // last pin level for edge detection

  // pin history, kept running so a source change sees a clean edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_pin;
    end
  end

  // registered tick; select zero yields none
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_tick <= 1'b0;
    end else if (!run_enable) begin
      timer_tick <= 1'b0;
    end else begin
      case (tick_source_select)
        `TMR16_SEL_NONE:     timer_tick <= 1'b0;
        `TMR16_SEL_SYSCLK:   timer_tick <= 1'b1;
        3'h2:                timer_tick <= prescale_tick[0];
        3'h3:                timer_tick <= prescale_tick[1];
        3'h4:                timer_tick <= prescale_tick[2];
        3'h5:                timer_tick <= prescale_tick[3];
        `TMR16_SEL_EXT_FALL: timer_tick <= ext_prev & ~ext_pin;
        `TMR16_SEL_EXT_RISE: timer_tick <= ~ext_prev & ext_pin;
        default:             timer_tick <= 1'b0;
      endcase
    end
  end
endmodule // tmr16_tick_sel
`default_nettype wire

// ---- tmr16_core.v ----
// top of the 16-bit timer: APB register file, byte access path, counter unit
// assumes a 32-bit APB master and an outside prescaler supplying tap strobes
//
// Implementation choices: the address map and the APB register port.
`include "tmr16_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr16_core (
  input  wire        pclk,           // system clock
  input  wire        presetn,        // async reset, active low
  input  wire        psel,           // APB select
  input  wire        penable,        // APB access phase
  input  wire        pwrite,         // APB direction
  input  wire [11:0] paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output reg  [31:0] prdata,         // APB read data
  output reg         pready,         // APB ready
  output reg         pslverr,        // APB error on unmapped address
  input  wire [3:0]  prescale_tick,  // prescaler tap strobes
  input  wire        ext_pin,        // external count pin
  input  wire        capture_event,  // capture strobe from the capture unit
  output reg         overflow_flag,  // sticky overflow, interrupt request
  output reg         top_hit,        // count equals current top
  output reg         bottom_hit,     // count equals zero
  output reg         max_hit         // count equals all ones
);
  // mode codes of the four-bit wave field
  localparam [3:0] M_NORMAL  = 4'h0;
  localparam [3:0] M_PC8     = 4'h1;
  localparam [3:0] M_PC9     = 4'h2;
  localparam [3:0] M_PC10    = 4'h3;
  localparam [3:0] M_CTC_A   = 4'h4;
  localparam [3:0] M_FAST8   = 4'h5;
  localparam [3:0] M_FAST9   = 4'h6;
  localparam [3:0] M_FAST10  = 4'h7;
  localparam [3:0] M_PFC_CAP = 4'h8;
  localparam [3:0] M_PFC_A   = 4'h9;
  localparam [3:0] M_PC_CAP  = 4'hA;
  localparam [3:0] M_PC_A    = 4'hB;
  localparam [3:0] M_CTC_CAP = 4'hC;
  localparam [3:0] M_FST_CAP = 4'hE;
  localparam [3:0] M_FAST_A  = 4'hF;

  // count direction states, one-hot
  localparam [1:0] DIR_UP    = 2'b01;
  localparam [1:0] DIR_DOWN  = 2'b10;

  reg  [7:0]  control_reg_a;      // low wave bits
  reg  [7:0]  control_reg_b;      // tick select and high wave bits
  reg  [7:0]  high_latch;         // the single shared high-byte latch
  reg  [15:0] count_value;        // the counter
  reg  [15:0] compare_value_a;    // compare A, also a top source
  reg  [15:0] compare_value_b;    // compare B
  reg  [15:0] capture_value;      // capture, also a top source
  reg         timer_power_off;    // module disable
  reg  [1:0]  dir_state;          // up or down slope
  reg  [15:0] next_count;         // counter value for this edge
  reg  [1:0]  next_dir;           // direction for this edge
  reg         next_ovf;           // overflow event this edge
  reg  [31:0] rd_word;            // read data before the register
  reg         rd_hit;             // address is mapped
  wire        timer_tick;         // count strobe from the selector
  wire [3:0]  wave_mode_field;    // assembled mode
  wire [2:0]  tick_source_select; // assembled source
  wire [15:0] top_now;            // current sequence top
  wire        xfer;               // completing APB transfer
  wire        wr;                 // completing write
  wire        rd;                 // read sampling edge, one before completion
  wire [7:0]  wbyte;              // written byte

  assign wave_mode_field    = {control_reg_b[`TMR16_B_WAVE_HI], control_reg_a[`TMR16_A_WAVE_LO]};
  assign tick_source_select = control_reg_b[`TMR16_B_TICK_SEL];
  assign xfer  = psel & penable & pready;
  assign wr    = xfer & pwrite;
  assign rd    = psel & penable & ~pready & ~pwrite;
  assign wbyte = pwdata[7:0];

  // top of sequence for a mode
  function [15:0] top_of;
    input [3:0]  mode;
    input [15:0] cmp_a;
    input [15:0] capt;
    begin
      case (mode)
        M_PC8, M_FAST8:                      top_of = `TMR16_TOP_8BIT;
        M_PC9, M_FAST9:                      top_of = `TMR16_TOP_9BIT;
        M_PC10, M_FAST10:                    top_of = `TMR16_TOP_10BIT;
        M_CTC_A, M_PFC_A, M_PC_A, M_FAST_A:  top_of = cmp_a;
        M_PFC_CAP, M_PC_CAP, M_CTC_CAP, M_FST_CAP: top_of = capt;
        default:                             top_of = `TMR16_MAX;
      endcase
    end
  endfunction

  // dual-slope modes count up then down
  function is_dual;
    input [3:0] mode;
    begin
      case (mode)
        M_PC8, M_PC9, M_PC10, M_PFC_CAP, M_PFC_A, M_PC_CAP, M_PC_A: is_dual = 1'b1;
        default: is_dual = 1'b0;
      endcase
    end
  endfunction

  // capture is writable only where it sets the top
  function capt_is_top;
    input [3:0] mode;
    begin
      capt_is_top = (mode == M_PFC_CAP) || (mode == M_PC_CAP) ||
                    (mode == M_CTC_CAP) || (mode == M_FST_CAP);
    end
  endfunction

  assign top_now = top_of(wave_mode_field, compare_value_a, capture_value);

  // tick source and prescaler tap selection
  tmr16_tick_sel u_tick_sel (
    .pclk               (pclk),
    .presetn            (presetn),
    .run_enable         (~timer_power_off),
    .tick_source_select (tick_source_select),
    .prescale_tick      (prescale_tick),
    .ext_pin            (ext_pin),
    .timer_tick         (timer_tick)
  );

  // counting sequence per mode; writes are folded in later
  always @* begin
    next_count = count_value;
    next_dir   = dir_state;
    next_ovf   = 1'b0;
    if (timer_tick) begin
      if (is_dual(wave_mode_field)) begin
        case (dir_state)
          DIR_UP: begin
            if (count_value >= top_now) begin
              next_dir   = DIR_DOWN;
              next_count = count_value - 16'h0001;
            end else begin
              next_count = count_value + 16'h0001;
            end
          end
          DIR_DOWN: begin
            if (count_value == `TMR16_BOTTOM) begin
              next_dir   = DIR_UP;
              next_count = count_value + 16'h0001;
              next_ovf   = 1'b1;
            end else begin
              next_count = count_value - 16'h0001;
            end
          end
          default: begin
            next_dir   = DIR_UP;
            next_count = `TMR16_BOTTOM;
          end
        endcase
      end else begin
        next_dir = DIR_UP;
        if (wave_mode_field == M_NORMAL || wave_mode_field == M_CTC_A ||
            wave_mode_field == M_CTC_CAP) begin
          // normal and clear-on-match flag only the wrap from all ones
          next_ovf   = (count_value == `TMR16_MAX);
          next_count = (count_value == top_now) ? `TMR16_BOTTOM : count_value + 16'h0001;
        end else begin
          // fast modes flag at top
          next_ovf   = (count_value == top_now);
          next_count = (count_value >= top_now) ? `TMR16_BOTTOM : count_value + 16'h0001;
        end
      end
    end
  end

  // counter and direction; a software write wins over counting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= `TMR16_RST_WORD;
      dir_state   <= DIR_UP;
    end else if (wr && !timer_power_off && paddr == `TMR16_OFF_COUNT_LOW) begin
      // writing mid-count in dual modes can skew the slope; software avoids it
      count_value <= {high_latch, wbyte};
    end else begin
      count_value <= next_count;
      dir_state   <= next_dir;
    end
  end

  // overflow flag: event beats the write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (next_ovf && !(wr && paddr == `TMR16_OFF_COUNT_LOW)) begin
      overflow_flag <= 1'b1;
    end else if (wr && paddr == `TMR16_OFF_FLAGS && pwdata[`TMR16_FLAG_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // landmark indications, registered from the counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_hit    <= 1'b0;
      bottom_hit <= 1'b0;
      max_hit    <= 1'b0;
    end else begin
      top_hit    <= (count_value == top_now);
      bottom_hit <= (count_value == `TMR16_BOTTOM);
      max_hit    <= (count_value == `TMR16_MAX);
    end
  end

  // byte-wide control and 16-bit data registers, the 16-bit ones through one latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_a   <= `TMR16_RST_BYTE;
      control_reg_b   <= `TMR16_RST_BYTE;
      high_latch      <= `TMR16_RST_BYTE;
      compare_value_a <= `TMR16_RST_WORD;
      compare_value_b <= `TMR16_RST_WORD;
      capture_value   <= `TMR16_RST_WORD;
      timer_power_off <= 1'b0;
    end else begin
      // capture unit strobe copies the counter unless capture defines top or the timer is powered off
      if (capture_event && !capt_is_top(wave_mode_field) && !timer_power_off) begin
        capture_value <= count_value;
      end
      if (wr && paddr == `TMR16_OFF_POWER) begin
        timer_power_off <= pwdata[`TMR16_POWER_OFF_BIT];
      end else if (wr && !timer_power_off) begin
        case (paddr)
          `TMR16_OFF_CTRL_A:     control_reg_a <= wbyte;
          `TMR16_OFF_CTRL_B:     control_reg_b <= {3'h0, wbyte[4:0]};
          // every high location feeds the one latch
          `TMR16_OFF_COUNT_HIGH,
          `TMR16_OFF_CMP_A_HIGH,
          `TMR16_OFF_CMP_B_HIGH,
          `TMR16_OFF_CAPT_HIGH:  high_latch <= wbyte;
          `TMR16_OFF_CMP_A_LOW:  compare_value_a <= {high_latch, wbyte};
          `TMR16_OFF_CMP_B_LOW:  compare_value_b <= {high_latch, wbyte};
          `TMR16_OFF_CAPT_LOW: begin
            if (capt_is_top(wave_mode_field)) begin
              capture_value <= {high_latch, wbyte};
            end
          end
          default: begin
          end
        endcase
      end else if (rd && !timer_power_off) begin
        // count and capture low reads snapshot the high half on the edge the low byte is sampled
        case (paddr)
          `TMR16_OFF_COUNT_LOW: high_latch <= count_value[15:8];
          `TMR16_OFF_CAPT_LOW:  high_latch <= capture_value[15:8];
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; compare reads never touch the latch
  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr)
      `TMR16_OFF_CTRL_A:     rd_word = {24'h000000, control_reg_a};
      `TMR16_OFF_CTRL_B:     rd_word = {24'h000000, control_reg_b};
      `TMR16_OFF_COUNT_LOW:  rd_word = {24'h000000, count_value[7:0]};
      `TMR16_OFF_COUNT_HIGH: rd_word = {24'h000000, high_latch};
      `TMR16_OFF_CMP_A_LOW:  rd_word = {24'h000000, compare_value_a[7:0]};
      `TMR16_OFF_CMP_A_HIGH: rd_word = {24'h000000, compare_value_a[15:8]};
      `TMR16_OFF_CMP_B_LOW:  rd_word = {24'h000000, compare_value_b[7:0]};
      `TMR16_OFF_CMP_B_HIGH: rd_word = {24'h000000, compare_value_b[15:8]};
      `TMR16_OFF_CAPT_LOW:   rd_word = {24'h000000, capture_value[7:0]};
      `TMR16_OFF_CAPT_HIGH:  rd_word = {24'h000000, high_latch};
      `TMR16_OFF_FLAGS:      rd_word = {31'h00000000, overflow_flag};
      `TMR16_OFF_POWER:      rd_word = {31'h00000000, timer_power_off};
      default:               rd_hit  = 1'b0;
    endcase
  end

  // APB handshake: one wait state, data and error registered with ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      if (rd) begin
        // low byte and latch copy share this edge, so no carry can split them
        prdata <= rd_word;
      end
    end
  end
endmodule // tmr16_core
`default_nettype wire

// ---- tmr16_sva.sv ----
// checker for the byte-access timer: bus handshake, error, flag and counter-hold relations
// assumes binding onto tmr16_core and the register map of tmr16_consts.vh
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_consts.vh"
module tmr16_sva (
  input wire logic        pclk,          // system clock
  input wire logic        presetn,       // async reset, active low
  input wire logic        psel,          // bus select
  input wire logic        penable,       // access phase
  input wire logic        pwrite,        // direction
  input wire logic [11:0] paddr,         // byte address
  input wire logic [31:0] pwdata,        // write data
  input wire logic [31:0] prdata,        // read data
  input wire logic        pready,        // ready pulse
  input wire logic        pslverr,       // error
  input wire logic        overflow_flag, // sticky overflow
  input wire logic        top_hit,       // count at top
  input wire logic        bottom_hit,    // count at zero
  input wire logic        max_hit        // count all ones
);
  // a completed write, the only moment a write lands
  wire wr_done = psel && penable && pready && pwrite;
  reg  [1:0] still; // cycles since ticks were switched off, saturating at 3

  // margin of two cycles covers a tick already in the selector pipe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      still <= 2'h0;
    end else if (wr_done && paddr == `TMR16_OFF_CTRL_B) begin
      still <= (pwdata[2:0] == 3'h0) ? 2'h1 : 2'h0;
    end else if (still != 2'h0 && still != 2'h3) begin
      still <= still + 2'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_one_late_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (psel && penable && pready && paddr > `TMR16_OFF_POWER |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && pready && paddr[1:0] == 2'h0 &&
    paddr <= `TMR16_OFF_POWER |-> !pslverr)
    else $error("mapped access refused");
  ovf_sticky_a: assert property (overflow_flag && !(wr_done && paddr == `TMR16_OFF_FLAGS && pwdata[0])
    |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  rdata_hold_a: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  stopped_hold_a: assert property (still == 2'h3 && !wr_done ##1 !wr_done
    |=> $stable(bottom_hit) && $stable(max_hit))
    else $error("counter moved with no tick source");
  hit_exclusive_a: assert property (bottom_hit |-> !max_hit)
    else $error("zero and all ones at once");

  cover property (pslverr);
  cover property ($rose(overflow_flag));
  cover property (top_hit && !bottom_hit);
endmodule // tmr16_sva

bind tmr16_core tmr16_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .overflow_flag, .top_hit, .bottom_hit, .max_hit);
`default_nettype wire

// ---- tmr16_cpu_model.sv ----
// byte-wide cpu model issuing bus transfers to the timer
// assumes one master only, so every two-byte sequence is uninterrupted
`timescale 1ns/1ps
`default_nettype none
module tmr16_cpu_model (
  input  wire logic        pclk,    // system clock
  output var  logic        psel,    // select
  output var  logic        penable, // access phase
  output var  logic        pwrite,  // direction
  output var  logic [11:0] paddr,   // byte address
  output var  logic [31:0] pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // one byte transfer; no interrupts exist here, so byte pairs stay atomic
  task xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // the bench timeout ends a hang, so no limit here
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep the old value
    paddr <= ~a;
    pwdata <= {24'hFFFFFF, ~d};
  endtask
endmodule // tmr16_cpu_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the byte-access timer
// assumes the cpu model drives the bus and random strobes feed the tick inputs
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_consts.vh"
module tb;
  logic        pclk = 1'b0, presetn = 1'b0;        // clock, reset
  logic        psel, penable, pwrite, pready, pslverr; // bus controls
  logic [11:0] paddr;                                 // address
  logic [31:0] pwdata, prdata;                        // data
  logic [3:0]  prescale_tick = 4'h0;                  // random tap strobes
  logic        ext_pin = 1'b0, capture_event = 1'b0;  // pin and capture strobe
  logic        overflow_flag, top_hit, bottom_hit, max_hit; // indications
  int          miscompares = 0, total_checks = 0, cycles = 0;
  logic [31:0] seed = 32'h000016C6;                   // fixed seed

  tmr16_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prescale_tick, .ext_pin, .capture_event, .overflow_flag, .top_hit, .bottom_hit, .max_hit);
  tmr16_cpu_model cpu_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  always #2.5 pclk = ~pclk;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected top for the up-counting modes used below
  function logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h5: return `TMR16_TOP_8BIT;
      4'h6: return `TMR16_TOP_9BIT;
      4'h7: return `TMR16_TOP_10BIT;
      4'hC: return 16'h0234;
      default: return 16'h0123;
    endcase
  endfunction

  // random tick inputs each cycle, plus the hang limit
  always @(posedge pclk) begin
    {ext_pin, prescale_tick} <= 5'(rnd());
    cycles <= cycles + 1;
    if (cycles >= 20000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    cpu_u.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, output logic [7:0] q);
    logic e;
    cpu_u.xfer(1'b0, a, 8'h00, q, e);
  endtask
  // high byte first on writes, low byte first on reads
  task w16(input logic [11:0] lo, input logic [15:0] v);
    wr(lo + 12'h004, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task r16(input logic [11:0] lo, output logic [15:0] v);
    logic [7:0] l, h;
    rd(lo, l);
    rd(lo + 12'h004, h);
    v = {h, l};
  endtask
  task set_mode(input logic [3:0] m, input logic [2:0] s);
    wr(`TMR16_OFF_CTRL_A, {6'h00, m[1:0]});
    wr(`TMR16_OFF_CTRL_B, {3'h0, m[3:2], s});
  endtask
  // bounded wait for top (0), all ones (1) or overflow (2)
  // short window: a wrong top would be reached far too late
  task wait_hit(input int w);
    int n;
    n = 0;
    while (n < 20 && ((w == 0) ? top_hit : (w == 1) ? max_hit : overflow_flag) !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk({15'h0000, n < 20}, 16'h0001);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    logic [15:0] v, x, h;
    logic [7:0]  b;
    logic [3:0]  modes [6];
    logic        e;
    int          i, s;
    modes = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hF};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({15'h0000, bottom_hit}, 16'h0001);
    // full words through the byte path, corner value first
    for (i = 0; i < 6; i++) begin
      x = (i == 0) ? 16'h01FF : 16'(rnd());
      w16(`TMR16_OFF_COUNT_LOW, x);
      r16(`TMR16_OFF_COUNT_LOW, v);
      chk(v, x);
    end
    // one latch load serves both compares; compare reads leave the latch alone
    h = 16'(rnd());
    wr(`TMR16_OFF_CMP_A_HIGH, h[7:0]);
    wr(`TMR16_OFF_CMP_A_LOW, h[15:8]);
    wr(`TMR16_OFF_CMP_B_LOW, ~h[15:8]);
    rd(`TMR16_OFF_COUNT_LOW, b);
    r16(`TMR16_OFF_CMP_A_LOW, v);
    chk(v, {h[7:0], h[15:8]});
    r16(`TMR16_OFF_CMP_B_LOW, v);
    chk(v, {h[7:0], ~h[15:8]});
    rd(`TMR16_OFF_COUNT_HIGH, b);
    chk({8'h00, b}, {8'h00, x[15:8]});
    // lone high access hits the latch, not the counter
    wr(`TMR16_OFF_COUNT_HIGH, 8'h5A);
    rd(`TMR16_OFF_COUNT_HIGH, b);
    chk({8'h00, b}, 16'h005A);
    r16(`TMR16_OFF_COUNT_LOW, v);
    chk(v, x);
    // capture low read refills the latch shared with the counter
    capture_event <= 1'b1;
    @(posedge pclk);
    capture_event <= 1'b0;
    w16(`TMR16_OFF_COUNT_LOW, ~x);
    rd(`TMR16_OFF_CAPT_LOW, b);
    chk({8'h00, b}, {8'h00, x[7:0]});
    rd(`TMR16_OFF_COUNT_HIGH, b);
    chk({8'h00, b}, {8'h00, x[15:8]});
    // unmapped place and reserved control bits
    cpu_u.xfer(1'b0, 12'h030, 8'h00, b, e);
    chk({15'h0000, e}, 16'h0001);
    wr(`TMR16_OFF_CTRL_B, 8'hE0);
    rd(`TMR16_OFF_CTRL_B, b);
    chk({8'h00, b}, 16'h0000);
    // every tick source advances the count, select zero freezes it
    for (s = 1; s < 8; s++) begin
      w16(`TMR16_OFF_COUNT_LOW, 16'h0000);
      set_mode(4'h0, 3'(s));
      repeat (40) @(posedge pclk);
      set_mode(4'h0, 3'h0);
      r16(`TMR16_OFF_COUNT_LOW, v);
      chk({15'h0000, v != 16'h0000 && v < 16'h0050}, 16'h0001);
      repeat (10) @(posedge pclk);
      r16(`TMR16_OFF_COUNT_LOW, x);
      chk(x, v);
    end
    // wrap past all ones sets the overflow, a one written clears it
    w16(`TMR16_OFF_COUNT_LOW, 16'hFFF8);
    set_mode(4'h0, 3'h1);
    wait_hit(1);
    wait_hit(2);
    set_mode(4'h0, 3'h0);
    wr(`TMR16_OFF_FLAGS, 8'h01);
    @(posedge pclk);
    chk({15'h0000, overflow_flag}, 16'h0000);
    // a write while counting still lands; the read straddles a carry,
    // so bytes taken on different edges would show up as 0x81xx
    set_mode(4'h0, 3'h1);
    w16(`TMR16_OFF_COUNT_LOW, 16'h80FD);
    r16(`TMR16_OFF_COUNT_LOW, v);
    chk({15'h0000, v >= 16'h80FD && v < 16'h8110}, 16'h0001);
    // top from fixed values, compare A and capture
    w16(`TMR16_OFF_CMP_A_LOW, 16'h0123);
    for (i = 0; i < 6; i++) begin
      set_mode(modes[i], 3'h0);
      if (modes[i] == 4'hC) begin
        w16(`TMR16_OFF_CAPT_LOW, 16'h0234);
      end
      w16(`TMR16_OFF_COUNT_LOW, top_of(modes[i]) - 16'h0006);
      wr(`TMR16_OFF_CTRL_B, {3'h0, modes[i][3:2], 3'h1});
      wait_hit(0);
    end
    // powered off, counter writes have no effect
    set_mode(4'h0, 3'h0);
    w16(`TMR16_OFF_COUNT_LOW, 16'h1234);
    wr(`TMR16_OFF_POWER, 8'h01);
    w16(`TMR16_OFF_COUNT_LOW, 16'h4321);
    wr(`TMR16_OFF_POWER, 8'h00);
    r16(`TMR16_OFF_COUNT_LOW, v);
    chk(v, 16'h1234);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
